// ### tcpc_sync.sv
// shared constants of the type-c port control block, and its input synchroniser
// assumes one 125 mhz clock and a low-active asynchronous reset
package tcpc_pkg;
  // clock rate and times
  localparam int unsigned CLK_MHZ = 125;
  localparam int unsigned DRP_HALF_US = 35000;
  localparam int unsigned DRP_HALF_CYC = DRP_HALF_US * CLK_MHZ;
  localparam int unsigned FAULT_PULSE_US = 1000;
  localparam int unsigned FAULT_PULSE_CYC = FAULT_PULSE_US * CLK_MHZ;
  localparam logic [2:0] STRAP_SETTLE_CYC = 3'h4;
  // register map
  localparam logic [11:0] CTRL_OFFS = 12'h000;
  localparam logic [11:0] STATUS_OFFS = 12'h004;
  localparam int CTRL_DISABLE_BIT = 0;
  localparam logic CTRL_RESET = 1'h0;
  localparam int ST_ATTACHED_BIT = 0;
  localparam int ST_SOURCE_BIT = 1;
  localparam int ST_ORIENT_BIT = 2;
  localparam int ST_LEVEL_POS = 3;
  localparam int ST_ROLE_POS = 5;
  localparam int ST_FAULT_BIT = 7;
  localparam int ST_STRAP_BIT = 8;
  // tri-level strap codes
  localparam logic [1:0] TRI_LOW = 2'h0;
  localparam logic [1:0] TRI_MID = 2'h1;
  localparam logic [1:0] TRI_HIGH = 2'h2;
  // partner advertisement seen on a cc line while sinking
  localparam logic [1:0] LVL_NONE = 2'h0;
  localparam logic [1:0] LVL_DEF = 2'h1;
  localparam logic [1:0] LVL_MED = 2'h2;
  localparam logic [1:0] LVL_HIGH = 2'h3;
  // port roles, same codes as the role strap levels
  localparam logic [1:0] ROLE_SNK = TRI_LOW;
  localparam logic [1:0] ROLE_DRP = TRI_MID;
  localparam logic [1:0] ROLE_SRC = TRI_HIGH;
  localparam int SYNC_W = 12;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_UNATT_SRC,
    ST_UNATT_SNK,
    ST_WAIT_VBUS,
    ST_ATT_SRC,
    ST_ATT_SNK
  } tcpcState_e;
endpackage

// three synchroniser flops per bit plus an output flop; output follows once the second and third agree
module tcpc_sync #(
  parameter int W = 1
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] s1Q, s2Q, s3Q, outQ;
  logic [W-1:0] outD;

  // take a bit only when the last two stages match
  always_comb
  begin
    outD = outQ;
    for (int i = 0; i < W; i++)
    begin
      if (s2Q[i] == s3Q[i])
      begin
        outD[i] = s3Q[i];
      end
    end
  end

  // first stage feeds the second and nothing else
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s1Q <= '0;
      s2Q <= '0;
      s3Q <= '0;
      outQ <= '0;
    end
    else
    begin
      s1Q <= d;
      s2Q <= s1Q;
      s3Q <= s2Q;
      outQ <= outD;
    end
  end

  assign q = outQ;
endmodule

// ### tcpc_port_control.sv
// type-c configuration channel port control: role straps, attach, orientation,
// current detect and cable supply fault on open-drain outputs, apb status
// assumes an analog front end giving digital cc comparator results and strap levels
//
// Design decisions made here: the address map and the APB slave port.
module tcpc_port_control
  import tcpc_pkg::*;
#(
  parameter int unsigned DRP_HALF_CYCLES = tcpc_pkg::DRP_HALF_CYC,
  parameter int unsigned FAULT_CYCLES = tcpc_pkg::FAULT_PULSE_CYC
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic roleAboveLow,
  input wire logic roleAboveHigh,
  input wire logic curAboveLow,
  input wire logic curAboveHigh,
  input wire logic cc1PullDownSeen,
  input wire logic cc2PullDownSeen,
  input wire logic [1:0] cc1SinkLevel,
  input wire logic [1:0] cc2SinkLevel,
  input wire logic busPowerSense,
  input wire logic vconnOvercurrent,
  output logic ccPullUpEn,
  output logic ccPullDownEn,
  output logic [1:0] ccCurrentSel,
  output logic cableSupplyFaultNOe,
  output logic currentDetectFlagAOe,
  output logic currentDetectFlagBOe,
  output logic sourceAttachNOe,
  output logic orientNOe,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  import tcpc_pkg::*;

  function automatic logic [1:0] decodeTri(input logic aboveLow, input logic aboveHigh);
    decodeTri = aboveHigh ? TRI_HIGH : (aboveLow ? TRI_MID : TRI_LOW);
  endfunction

  function automatic logic isSrc(input tcpcState_e s);
    isSrc = (s == ST_UNATT_SRC) || (s == ST_ATT_SRC);
  endfunction

  function automatic logic isAttached(input tcpcState_e s);
    isAttached = (s == ST_ATT_SRC) || (s == ST_ATT_SNK);
  endfunction

  // all front-end inputs pass the three-flop synchroniser; the apb pins do not
  logic [SYNC_W-1:0] syncIn, syncOut;
  logic rl, rh, cl, ch, rd1, rd2, vbus, ocur;
  logic [1:0] lvl1, lvl2;
  assign syncIn = {vconnOvercurrent, busPowerSense, cc2SinkLevel, cc1SinkLevel,
                   cc2PullDownSeen, cc1PullDownSeen, curAboveHigh, curAboveLow,
                   roleAboveHigh, roleAboveLow};
  tcpc_sync #(.W(SYNC_W)) uSync (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .d(syncIn),
    .q(syncOut)
  );
  assign {ocur, vbus, lvl2, lvl1, rd2, rd1, ch, cl, rh, rl} = syncOut;

  logic [1:0] curLevel;
  assign curLevel = decodeTri(cl, ch);

  // startup strap capture
  logic [2:0] settleQ, settleD;
  logic strapDoneQ, strapDoneD;
  logic [1:0] roleQ, roleD;

  always_comb
  begin
    settleD = settleQ;
    strapDoneD = strapDoneQ;
    roleD = roleQ;
    if (!strapDoneQ)
    begin
      settleD = settleQ + 3'h1;
      if (settleQ == STRAP_SETTLE_CYC)
      begin
        strapDoneD = 1'b1;
        roleD = decodeTri(rl, rh);
      end
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      settleQ <= 3'h0;
      strapDoneQ <= 1'b0;
      roleQ <= ROLE_SNK;
    end
    else
    begin
      settleQ <= settleD;
      strapDoneQ <= strapDoneD;
      roleQ <= roleD;
    end
  end

  // control register
  logic ctrlDisableQ, ctrlDisableD;

  // attach state machine with dual-role toggle timer
  tcpcState_e stateQ, stateD;
  logic [31:0] timerQ, timerD;
  logic orientQ, orientD;
  logic [1:0] partnerLvlQ, partnerLvlD;
  logic timerDone, anyRd, anyLvl;
  logic [1:0] activeLvl;
  assign timerDone = (timerQ == DRP_HALF_CYCLES - 1);
  assign anyRd = rd1 | rd2;
  assign anyLvl = (lvl1 != LVL_NONE) || (lvl2 != LVL_NONE);
  assign activeLvl = orientQ ? lvl2 : lvl1;

  always_comb
  begin
    stateD = stateQ;
    orientD = orientQ;
    partnerLvlD = partnerLvlQ;
    unique case (stateQ)
      ST_IDLE:
      begin
        if (strapDoneQ)
        begin
          stateD = (roleQ == ROLE_SRC) ? ST_UNATT_SRC : ST_UNATT_SNK;
        end
      end
      ST_UNATT_SRC:
      begin
        if (anyRd)
        begin
          stateD = ST_ATT_SRC;
          orientD = ~rd1;
        end
        else if (roleQ == ROLE_DRP && timerDone)
        begin
          stateD = ST_UNATT_SNK;
        end
      end
      ST_UNATT_SNK:
      begin
        if (anyLvl)
        begin
          stateD = ST_WAIT_VBUS;
          orientD = (lvl1 == LVL_NONE);
        end
        else if (roleQ == ROLE_DRP && timerDone)
        begin
          stateD = ST_UNATT_SRC;
        end
      end
      ST_WAIT_VBUS:
      begin
        if (!anyLvl)
        begin
          stateD = ST_UNATT_SNK;
        end
        else if (vbus)
        begin
          stateD = ST_ATT_SNK;
        end
      end
      ST_ATT_SRC:
      begin
        if (!anyRd)
        begin
          stateD = (roleQ == ROLE_SRC) ? ST_UNATT_SRC : ST_UNATT_SNK;
        end
      end
      ST_ATT_SNK:
      begin
        partnerLvlD = activeLvl;
        if (!vbus)
        begin
          stateD = ST_UNATT_SNK;
        end
      end
    endcase
    if (ctrlDisableQ)
    begin
      stateD = ST_IDLE;
    end
    if (stateD != ST_ATT_SNK)
    begin
      partnerLvlD = LVL_NONE;
    end
    // timer restarts on every state change
    timerD = (stateD != stateQ) ? 32'h0 : timerQ + 32'h1;
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      stateQ <= ST_IDLE;
      timerQ <= 32'h0;
      orientQ <= 1'b0;
      partnerLvlQ <= LVL_NONE;
    end
    else
    begin
      stateQ <= stateD;
      timerQ <= timerD;
      orientQ <= orientD;
      partnerLvlQ <= partnerLvlD;
    end
  end

  // cable supply fault pulse; a new over-current during a pulse is ignored
  logic ocurQ;
  logic [31:0] faultCntQ, faultCntD;
  always_comb
  begin
    faultCntD = faultCntQ;
    if (faultCntQ != 32'h0)
    begin
      faultCntD = faultCntQ - 32'h1;
    end
    else if (ocur && !ocurQ)
    begin
      faultCntD = FAULT_CYCLES;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ocurQ <= 1'b0;
      faultCntQ <= 32'h0;
    end
    else
    begin
      ocurQ <= ocur;
      faultCntQ <= faultCntD;
    end
  end

  // pin drives, all registered
  logic pullUpD, pullDownD, faultOeD, flagAD, flagBD, srcAttD, orientOeD;
  logic [1:0] curSelD;
  always_comb
  begin
    pullUpD = isSrc(stateQ);
    curSelD = isSrc(stateQ) ? curLevel : TRI_LOW;
    pullDownD = (stateQ == ST_UNATT_SNK) || (stateQ == ST_WAIT_VBUS) || (stateQ == ST_ATT_SNK);
    faultOeD = (faultCntD != 32'h0);
    flagAD = (stateQ == ST_ATT_SNK) && (partnerLvlD >= LVL_MED);
    flagBD = (stateQ == ST_ATT_SNK) && (partnerLvlD == LVL_HIGH);
    srcAttD = (stateQ == ST_ATT_SRC);
    orientOeD = isAttached(stateQ) && !orientQ;
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ccPullUpEn <= 1'b0;
      ccPullDownEn <= 1'b0;
      ccCurrentSel <= TRI_LOW;
      cableSupplyFaultNOe <= 1'b0;
      currentDetectFlagAOe <= 1'b0;
      currentDetectFlagBOe <= 1'b0;
      sourceAttachNOe <= 1'b0;
      orientNOe <= 1'b0;
    end
    else
    begin
      ccPullUpEn <= pullUpD;
      ccPullDownEn <= pullDownD;
      ccCurrentSel <= curSelD;
      cableSupplyFaultNOe <= faultOeD;
      currentDetectFlagAOe <= flagAD;
      currentDetectFlagBOe <= flagBD;
      sourceAttachNOe <= srcAttD;
      orientNOe <= orientOeD;
    end
  end

  // apb slave, one wait state so every answer comes from a flop
  logic readyD, errD, accessHit, mapped;
  logic [31:0] rdataD, statusWord;
  assign mapped = (paddr == CTRL_OFFS) || (paddr == STATUS_OFFS);
  assign accessHit = psel && penable && pready;
  always_comb
  begin
    statusWord = 32'h0;
    statusWord[ST_ATTACHED_BIT] = isAttached(stateQ);
    statusWord[ST_SOURCE_BIT] = isSrc(stateQ);
    statusWord[ST_ORIENT_BIT] = orientQ;
    statusWord[ST_LEVEL_POS +: 2] = partnerLvlQ;
    statusWord[ST_ROLE_POS +: 2] = roleQ;
    statusWord[ST_FAULT_BIT] = cableSupplyFaultNOe;
    statusWord[ST_STRAP_BIT] = strapDoneQ;
    readyD = psel && penable && !pready;
    errD = readyD && !mapped;
    rdataD = 32'h0;
    if (readyD && !pwrite && paddr == CTRL_OFFS)
    begin
      rdataD[CTRL_DISABLE_BIT] = ctrlDisableQ;
    end
    else if (readyD && !pwrite && paddr == STATUS_OFFS)
    begin
      rdataD = statusWord;
    end
    ctrlDisableD = ctrlDisableQ;
    // write lands on the edge that completes the access
    if (accessHit && pwrite && paddr == CTRL_OFFS)
    begin
      ctrlDisableD = pwdata[CTRL_DISABLE_BIT];
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
      ctrlDisableQ <= CTRL_RESET;
    end
    else
    begin
      pready <= readyD;
      pslverr <= errD;
      prdata <= rdataD;
      ctrlDisableQ <= ctrlDisableD;
    end
  end

  // checks
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);

  sequence faultHeld;
    cableSupplyFaultNOe [*8];
  endsequence

  sequence drpSwapToSink;
    stateQ == ST_UNATT_SRC && roleQ == ROLE_DRP && timerDone && !anyRd && !ctrlDisableQ;
  endsequence

  AST_CUR_ADVERTISE: assert property (ccPullUpEn |-> ccCurrentSel == $past(curLevel))
    else $error("current advertisement does not follow strap");
  AST_ROLE_SOURCE: assert property ($past(stateQ) == ST_IDLE && stateQ == ST_UNATT_SRC
    |-> roleQ == ROLE_SRC)
    else $error("source presented without source strap");
  AST_ROLE_KEPT: assert property (strapDoneQ |=> strapDoneQ && $stable(roleQ))
    else $error("role changed after sampling");
  AST_SINK_VBUS: assert property ($rose(stateQ == ST_ATT_SNK) |-> $past(vbus))
    else $error("sink attached without bus power");
  AST_FAULT_PULSE: assert property ($rose(cableSupplyFaultNOe) |-> faultHeld)
    else $error("fault pulse too short");
  AST_FLAG_ORDER: assert property (currentDetectFlagBOe |-> currentDetectFlagAOe)
    else $error("flag b low without flag a");
  AST_FLAG_HIGH: assert property (stateQ == ST_ATT_SNK && !ctrlDisableQ && vbus
    && activeLvl == LVL_HIGH |=> currentDetectFlagBOe)
    else $error("high current not flagged");
  AST_SRC_ATTACH: assert property (stateQ == ST_ATT_SRC |=> sourceAttachNOe)
    else $error("source attach not reported");
  AST_ORIENT: assert property (isAttached(stateQ) && !orientQ |=> orientNOe)
    else $error("position 1 not reported");
  AST_CC_ATTACH: assert property (stateQ == ST_UNATT_SRC && anyRd && !ctrlDisableQ
    |=> stateQ == ST_ATT_SRC)
    else $error("pull-down not taken as attach");
  AST_DRP_TOGGLE: assert property (drpSwapToSink |=> stateQ == ST_UNATT_SNK)
    else $error("dual-role did not swap");
  AST_RELEASED: assert property (!isAttached(stateQ) |=> !sourceAttachNOe && !orientNOe
    && !currentDetectFlagAOe && !currentDetectFlagBOe)
    else $error("output driven while unattached");
endmodule

// ### tcpc_remote_port.sv
// behavioural remote type-c port on the far side of the cc lines
// assumes the bench picks its role, plug side and advertised level
module tcpc_remote_port (
  input wire logic ccPullUpEn,
  input wire logic ccPullDownEn,
  input wire logic [1:0] farMode,
  input wire logic onCc2,
  input wire logic [1:0] farLevel,
  output logic cc1PullDownSeen,
  output logic cc2PullDownSeen,
  output logic [1:0] cc1SinkLevel,
  output logic [1:0] cc2SinkLevel
);
  timeunit 1ns;
  timeprecision 1ps;
  // mode 1 is a sink partner, mode 2 a source partner; a termination
  // only shows against the opposite one of ours, as on a real line
  always_comb
  begin
    cc1PullDownSeen = farMode == 2'h1 && ccPullUpEn && !onCc2;
    cc2PullDownSeen = farMode == 2'h1 && ccPullUpEn && onCc2;
    cc1SinkLevel = (farMode == 2'h2 && ccPullDownEn && !onCc2) ? farLevel : 2'h0;
    cc2SinkLevel = (farMode == 2'h2 && ccPullDownEn && onCc2) ? farLevel : 2'h0;
  end
endmodule

// ### tb_top.sv
// self-checking bench for the type-c port control block
// assumes the remote port model and short drp and fault counts
module tb_top;
  import tcpc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned DRP_N = 50;
  localparam int unsigned FLT_N = 20;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic roleAboveLow, roleAboveHigh, curAboveLow, curAboveHigh;
  logic busPowerSense, vconnOvercurrent, onCc2, psel, penable, pwrite, pready, pslverr;
  logic cc1PullDownSeen, cc2PullDownSeen, ccPullUpEn, ccPullDownEn;
  logic [1:0] farMode, farLevel, cc1SinkLevel, cc2SinkLevel, ccCurrentSel;
  logic cableSupplyFaultNOe, currentDetectFlagAOe, currentDetectFlagBOe;
  logic sourceAttachNOe, orientNOe, err, c2;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  int checks = 0;
  int n_mismatch = 0;
  int cyc = 0;
  int seed, n;

  tcpc_port_control #(.DRP_HALF_CYCLES(DRP_N), .FAULT_CYCLES(FLT_N)) tcpc_port_control_i (
    .ref_clk(ref_clk), .reset_n(reset_n), .roleAboveLow(roleAboveLow),
    .roleAboveHigh(roleAboveHigh), .curAboveLow(curAboveLow), .curAboveHigh(curAboveHigh),
    .cc1PullDownSeen(cc1PullDownSeen), .cc2PullDownSeen(cc2PullDownSeen),
    .cc1SinkLevel(cc1SinkLevel), .cc2SinkLevel(cc2SinkLevel), .busPowerSense(busPowerSense),
    .vconnOvercurrent(vconnOvercurrent), .ccPullUpEn(ccPullUpEn), .ccPullDownEn(ccPullDownEn),
    .ccCurrentSel(ccCurrentSel), .cableSupplyFaultNOe(cableSupplyFaultNOe),
    .currentDetectFlagAOe(currentDetectFlagAOe), .currentDetectFlagBOe(currentDetectFlagBOe),
    .sourceAttachNOe(sourceAttachNOe), .orientNOe(orientNOe), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));

  tcpc_remote_port tcpc_remote_port_i (
    .ccPullUpEn(ccPullUpEn), .ccPullDownEn(ccPullDownEn), .farMode(farMode), .onCc2(onCc2),
    .farLevel(farLevel), .cc1PullDownSeen(cc1PullDownSeen), .cc2PullDownSeen(cc2PullDownSeen),
    .cc1SinkLevel(cc1SinkLevel), .cc2SinkLevel(cc2SinkLevel));

  // free-running clock, 8 ns period
  always #4 ref_clk = ~ref_clk;

  // hang guard, far above the roughly six hundred cycles the run needs
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 8000)
    begin
      n_mismatch++;
      results();
    end
  end

  task automatic results();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  // expected open-drain enables, 1 = pin pulled low
  function automatic logic [31:0] expFlagA(input int lvl);
    expFlagA = 32'(lvl >= int'(LVL_MED));
  endfunction

  function automatic logic [31:0] expFlagB(input int lvl);
    expFlagB = 32'(lvl == int'(LVL_HIGH));
  endfunction

  // plug position 1 pulls the orientation pin low
  function automatic logic [31:0] expOrient(input logic onSecond);
    expOrient = 32'(!onSecond);
  endfunction

  task automatic tick(input int k);
    repeat (k) @(posedge ref_clk);
  endtask

  // strap the role, then reset; the strap is taken shortly after release
  task automatic boot(input logic [1:0] role);
    reset_n <= 1'b0;
    roleAboveLow <= role != TRI_LOW;
    roleAboveHigh <= role == TRI_HIGH;
    farMode <= 2'h0;
    busPowerSense <= 1'b0;
    tick(8);
    reset_n <= 1'b1;
    tick(16);
  endtask

  // one apb transfer; entered just after an edge, holds until pready
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    tick(1);
    penable <= 1'b1;
    tick(1);
    // a wait that never ends is left to the watchdog
    while (pready !== 1'b1)
    begin
      tick(1);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // one idle edge, so a following call never reassigns psel in this step
    tick(1);
  endtask

  initial
  begin
    seed = 54;
    {roleAboveLow, roleAboveHigh, busPowerSense, vconnOvercurrent, onCc2} = '0;
    {psel, penable, pwrite, farMode, farLevel} = '0;
    {curAboveLow, curAboveHigh} = 2'h3;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    tick(1);
    // sink: every partner level, random plug side, bus power gates attach
    boot(TRI_LOW);
    for (int i = 1; i < 4; i++)
    begin
      c2 = 1'($random(seed));
      farLevel <= 2'(i);
      onCc2 <= c2;
      farMode <= 2'h2;
      tick(16);
      chk("flagA unpowered", 0, currentDetectFlagAOe);
      chk("pullDown", 1, ccPullDownEn);
      apb(1'b0, STATUS_OFFS, 32'h0);
      chk("attached unpowered", 0, rd[ST_ATTACHED_BIT]);
      busPowerSense <= 1'b1;
      tick(16);
      chk("flagA", expFlagA(i), currentDetectFlagAOe);
      chk("flagB", expFlagB(i), currentDetectFlagBOe);
      chk("orient sink", expOrient(c2), orientNOe);
      chk("curSel sink", 0, ccCurrentSel);
      chk("srcAttach sink", 0, sourceAttachNOe);
      busPowerSense <= 1'b0;
      farMode <= 2'h0;
      tick(16);
      chk("flagA detached", 0, currentDetectFlagAOe);
    end
    // source: every current strap code, strap moved after sampling
    for (int i = 0; i < 3; i++)
    begin
      c2 = 1'($random(seed));
      curAboveLow <= i != 0;
      curAboveHigh <= i == 2;
      boot(TRI_HIGH);
      chk("srcAttach idle", 0, sourceAttachNOe);
      farMode <= 2'h1;
      onCc2 <= c2;
      roleAboveHigh <= 1'b0;
      tick(16);
      chk("curSel", 32'(i), ccCurrentSel);
      chk("srcAttach", 1, sourceAttachNOe);
      chk("orient src", expOrient(c2), orientNOe);
      apb(1'b0, STATUS_OFFS, 32'h0);
      chk("role kept", 32'(ROLE_SRC), 32'(rd[ST_ROLE_POS +: 2]));
    end
    // fault pulse length, with a second rising edge inside it ignored
    vconnOvercurrent <= 1'b1;
    while (cableSupplyFaultNOe !== 1'b1)
    begin
      tick(1);
    end
    // low for three edges so the drop survives the synchroniser
    n = 0;
    while (cableSupplyFaultNOe === 1'b1)
    begin
      tick(1);
      n++;
      vconnOvercurrent <= (n < 5 || n > 7);
    end
    chk("fault len", FLT_N, n);
    vconnOvercurrent <= 1'b0;
    // dual role: pull-up about half the time until a sink appears
    boot(TRI_MID);
    n = 0;
    repeat (2 * DRP_N + 10)
    begin
      tick(1);
      n += int'(ccPullUpEn);
    end
    chk("drp share", 1, 32'(n > DRP_N - 10 && n < DRP_N + 10));
    farMode <= 2'h1;
    tick(2 * DRP_N + 20);
    chk("srcAttach drp", 1, sourceAttachNOe);
    apb(1'b0, 12'h008, 32'h0);
    chk("unmapped err", 1, err);
    apb(1'b1, CTRL_OFFS, 32'h1);
    apb(1'b0, CTRL_OFFS, 32'h0);
    chk("ctrl readback", 1, rd[CTRL_DISABLE_BIT]);
    tick(16);
    chk("srcAttach off", 0, sourceAttachNOe);
    results();
  end
endmodule
